// File: logic/cpu_decode_pkg.sv
package cpu_decode_pkg;

   // Bus state codes, bit order {S0,S1,S2}
   typedef enum logic [2:0] {
      ST_WAIT    = 3'b000,
      ST_T2      = 3'b001,
      ST_T1      = 3'b010,
      ST_T1I     = 3'b011,
      ST_T3      = 3'b100,
      ST_T5      = 3'b101,
      ST_STOPPED = 3'b110,
      ST_T4      = 3'b111
   } bus_state_t;

   // Cycle type as {D7,D6} during T2
   localparam logic [1:0] CYC_FETCH = 2'h0;
   localparam logic [1:0] CYC_READ = 2'h2;
   localparam logic [1:0] CYC_IO = 2'h1;
   localparam logic [1:0] CYC_WRITE = 2'h3;

   // States per machine cycle
   localparam logic [2:0] LEN_SHORT = 3'h3;
   localparam logic [2:0] LEN_STORE = 3'h4;
   localparam logic [2:0] LEN_FULL = 3'h5;

   localparam logic [2:0] ALU_CMP = 3'h7;

   localparam logic [2:0] REG_A = 3'h0;
   localparam logic [2:0] REG_H = 3'h5;
   localparam logic [2:0] REG_L = 3'h6;
   localparam logic [2:0] REG_MEM = 3'h7;

   localparam logic [1:0] CYC_IDX_FIRST = 2'h0;
   localparam logic [1:0] CYC_IDX_SECOND = 2'h1;
   localparam logic [1:0] CYC_IDX_THIRD = 2'h2;

   localparam logic [13:0] PC_RESET = 14'h0000;
   localparam logic [2:0] SP_RESET = 3'h0;
   localparam logic [7:0] REG_RESET = 8'h00;

endpackage

// File: logic/cpu_instruction_decoder.sv
`timescale 1ns/1ps
// Overview of operation
// - Third jump byte: only low six bits used
// - Loads leave all four flags unchanged
// - Increment/decrement update Z,S,P; carry kept
// - ALU ops set all flags; rotates carry only
// - Register codes A,B,C,D,E,H,L; 111 is memory
// - Memory operand address is H high, L low
// - Condition field selects C,Z,S,P; P even
// - Add overflow or subtract borrow sets carry
// - ALU opcode forms for register, memory, immediate
// - Compare sets flags, accumulator unchanged
// - Four rotate opcodes, one bit each
// - Move in 5 states, immediate load in 8
// - Increment and decrement selected non-accumulator register
// - Jump loads PC from two bytes, 11 states
// - Bit 5 picks false/true; failed takes 9
// - Taken call pushes return address first
// - Return pops in 5; failed return 3
// - Restart pushes, jumps to aaa000
// - Input port mmm into accumulator, 8 states
// - Output accumulator to port rrmmm, 6 states
// - Halt opcodes stop until interrupt, 4 states
// - Memory ALU 8, store 7, immediate store 9
// - Cycle type on D7,D6 during T2
// - Logical and, xor, or clear carry
// - Eight-entry stack, 3-bit pointer wraps
module cpu_instruction_decoder
   import cpu_decode_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Multiplexed bus
   input wire logic [7:0] bus_in,
   output logic [7:0] bus_out,
   output logic bus_oe,
   output logic [2:0] state_code,
   // Control inputs
   input wire logic ready,
   input wire logic intr_req,
   // Status
   output logic [3:0] flags
);
   import cpu_decode_pkg::*;

   bus_state_t state_q, state_d;
   logic [1:0] cyc_q, cyc_d;
   logic [7:0] ir_q, tmp_b_q, tmp_hi_q;
   logic [7:0] regs_q [0:7];
   logic [13:0] stack_q [0:7];
   logic [2:0] sp_q;
   logic c_q, z_q, s_q, p_q;

   // Opcode is visible straight off the bus in the fetch T3
   wire fetch_t3 = (state_q == ST_T3) && (cyc_q == CYC_IDX_FIRST);
   wire [7:0] opc = fetch_t3 ? bus_in : ir_q;
   wire [2:0] dst = opc[5:3];
   wire [2:0] src = opc[2:0];
   wire grp0 = (opc[7:6] == 2'h0);
   wire grp1 = (opc[7:6] == 2'h1);
   wire grp2 = (opc[7:6] == 2'h2);

   wire op_hlt = (opc[7:1] == 7'h00) || (opc == 8'hff);
   wire op_move = (opc[7:6] == 2'h3) && !op_hlt;
   wire op_lrm = op_move && (src == REG_MEM);
   wire op_lmr = op_move && (dst == REG_MEM) && (src != REG_MEM);
   wire op_rr = op_move && !op_lrm && !op_lmr;
   wire op_alu_r = grp2 && (src != REG_MEM);
   wire op_alu_m = grp2 && (src == REG_MEM);
   wire op_alu_i = grp0 && (src == 3'h4);
   wire op_alu = op_alu_r || op_alu_m || op_alu_i;
   wire op_lri = grp0 && (src == 3'h6) && (dst != REG_MEM);
   wire op_lmi = grp0 && (src == 3'h6) && (dst == REG_MEM);
   wire op_inc = grp0 && (src == 3'h0) && (dst != REG_A) && (dst != REG_MEM);
   wire op_dec = grp0 && (src == 3'h1) && (dst != REG_A) && (dst != REG_MEM);
   wire op_rot = grp0 && (src == 3'h2) && !opc[5];
   wire op_ret = grp0 && (src == 3'h7);
   wire op_retc = grp0 && (src == 3'h3);
   wire op_rst = grp0 && (src == 3'h5);
   wire op_jmp = grp1 && (src == 3'h4);
   wire op_jc = grp1 && (src == 3'h0);
   wire op_cal = grp1 && (src == 3'h6);
   wire op_cc = grp1 && (src == 3'h2);
   wire op_in = grp1 && opc[0] && (opc[5:4] == 2'h0);
   wire op_out = grp1 && opc[0] && (opc[5:4] != 2'h0);
   wire op_load = op_rr || op_lrm || op_lri;

   // Condition select and sense
   wire [3:0] flag_vec = {p_q, s_q, z_q, c_q};
   wire cond_hit = (flag_vec[opc[4:3]] == opc[5]);
   wire op_cond = op_jc || op_cc || op_retc;
   wire taken = op_jmp || op_cal || op_ret || op_rst || (op_cond && cond_hit);
   wire op_three_byte = op_jmp || op_jc || op_cal || op_cc;
   wire op_push = ((op_cal || op_cc) && taken) || op_rst;
   wire op_jump_taken = (op_jmp || op_jc) && taken;
   wire op_pop = (op_ret || op_retc) && taken;

   // Cycle plan of the instruction
   wire full_second = op_lrm || op_alu_m || op_lri || op_alu_i || op_in;
   wire [1:0] last_cyc = (op_three_byte || op_lmi) ? CYC_IDX_THIRD :
      (full_second || op_lmr || op_out) ? CYC_IDX_SECOND : CYC_IDX_FIRST;
   wire short_fetch = op_hlt || full_second || op_three_byte || op_lmi || op_out ||
      (op_retc && !cond_hit);
   wire [2:0] len_first = op_lmr ? LEN_STORE : (short_fetch ? LEN_SHORT : LEN_FULL);
   wire [2:0] len_second = full_second ? LEN_FULL : LEN_SHORT;
   wire [2:0] len_third = (op_three_byte && taken) ? LEN_FULL : LEN_SHORT;
   wire [2:0] cur_len = (cyc_q == CYC_IDX_FIRST) ? len_first :
      (cyc_q == CYC_IDX_SECOND) ? len_second : len_third;
   wire [1:0] type_second = op_lmr ? CYC_WRITE : ((op_in || op_out) ? CYC_IO : CYC_READ);
   wire [1:0] type_third = op_lmi ? CYC_WRITE : CYC_READ;
   wire [1:0] cur_type = (cyc_q == CYC_IDX_FIRST) ? CYC_FETCH :
      (cyc_q == CYC_IDX_SECOND) ? type_second : type_third;
   wire use_hl = ((cyc_q == CYC_IDX_SECOND) && (op_lrm || op_alu_m || op_lmr)) ||
      ((cyc_q == CYC_IDX_THIRD) && op_lmi);
   wire is_io = (cur_type == CYC_IO);

   // Addresses
   wire [13:0] pc = stack_q[sp_q];
   wire [13:0] hl_addr = {regs_q[REG_H][5:0], regs_q[REG_L]};
   wire [13:0] addr = use_hl ? hl_addr : pc;
   wire [13:0] jump_target = {tmp_hi_q[5:0], tmp_b_q};
   wire [13:0] rst_target = {8'h00, opc[5:3], 3'h0};
   wire [2:0] sp_up = 3'(sp_q + 3'h1);
   wire [2:0] sp_dn = 3'(sp_q - 3'h1);

   // End of a machine cycle and of the instruction
   wire cyc_end = ((state_q == ST_T3) && (cur_len == LEN_SHORT) && !(fetch_t3 && op_hlt)) ||
      ((state_q == ST_T4) && (cur_len == LEN_STORE)) || (state_q == ST_T5);
   wire done = cyc_end && (cyc_q == last_cyc);
   wire pc_step = (state_q == ST_T2) && !use_hl && !is_io;
   wire write_t3 = (state_q == ST_T3) && (cur_type == CYC_WRITE);

   // Arithmetic unit
   wire [7:0] acc = regs_q[REG_A];
   wire [7:0] operand = op_alu_r ? regs_q[src] : tmp_b_q;
   wire use_cin = opc[3] && !opc[5];
   wire [8:0] cin9 = {8'h00, c_q && use_cin};
   wire [8:0] sum9 = 9'({1'b0, acc} + {1'b0, operand} + cin9);
   wire [8:0] diff9 = 9'({1'b0, acc} - {1'b0, operand} - cin9);
   wire [8:0] logic9 = opc[3] ? {1'b0, acc ^ operand} : {1'b0, acc & operand};
   wire [8:0] alu9 = !opc[5] ? (opc[4] ? diff9 : sum9) :
      (opc[4] ? (opc[3] ? diff9 : {1'b0, acc | operand}) : logic9);
   wire [7:0] idr = op_inc ? 8'(regs_q[dst] + 8'h01) : 8'(regs_q[dst] - 8'h01);
   wire [7:0] rot_res = opc[3] ? {(opc[4] ? c_q : acc[0]), acc[7:1]} :
      {acc[6:0], (opc[4] ? c_q : acc[7])};
   wire rot_c = opc[3] ? acc[0] : acc[7];

   // Bus drive by state
   assign bus_out = (state_q == ST_T1) ? (is_io ? acc : addr[7:0]) :
      (state_q == ST_T2) ? {cur_type, (is_io ? opc[5:0] : addr[13:8])} :
      write_t3 ? (op_lmi ? tmp_b_q : regs_q[src]) : 8'h00;
   assign bus_oe = (state_q == ST_T1) || (state_q == ST_T2) || write_t3;
   assign state_code = state_q;
   assign flags = {p_q, s_q, z_q, c_q};

   always_comb begin
      state_d = state_q;
      cyc_d = cyc_q;
      case (state_q)
         ST_T1: state_d = ST_T2;
         ST_T2: state_d = ready ? ST_T3 : ST_WAIT;
         ST_WAIT: state_d = ready ? ST_T3 : ST_WAIT;
         ST_T3: state_d = (fetch_t3 && op_hlt) ? ST_STOPPED : ST_T4;
         ST_T4: state_d = ST_T5;
         ST_T5: state_d = ST_T1;
         ST_STOPPED: state_d = intr_req ? ST_T1 : ST_STOPPED;
         default: state_d = ST_T1;
      endcase
      if (cyc_end) begin
         state_d = ST_T1;
         cyc_d = (cyc_q == last_cyc) ? CYC_IDX_FIRST : 2'(cyc_q + 2'h1);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_T1;
         cyc_q <= CYC_IDX_FIRST;
      end else begin
         state_q <= state_d;
         cyc_q <= cyc_d;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ir_q <= REG_RESET;
         tmp_b_q <= REG_RESET;
         tmp_hi_q <= REG_RESET;
      end else if (state_q == ST_T3 && cur_type != CYC_WRITE) begin
         case (cyc_q)
            CYC_IDX_FIRST: ir_q <= bus_in;
            CYC_IDX_SECOND: tmp_b_q <= bus_in;
            default: tmp_hi_q <= bus_in;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 8; i++) begin
            regs_q[i] <= REG_RESET;
         end
      end else if (done) begin
         if (op_rr) begin
            regs_q[dst] <= regs_q[src];
         end else if (op_lrm || op_lri) begin
            regs_q[dst] <= tmp_b_q;
         end else if (op_alu && (opc[5:3] != ALU_CMP)) begin
            regs_q[REG_A] <= alu9[7:0];
         end else if (op_inc || op_dec) begin
            regs_q[dst] <= idr;
         end else if (op_rot) begin
            regs_q[REG_A] <= rot_res;
         end else if (op_in) begin
            regs_q[REG_A] <= tmp_b_q;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         c_q <= 1'b0;
         z_q <= 1'b0;
         s_q <= 1'b0;
         p_q <= 1'b0;
      end else if (done) begin
         if (op_alu) begin
            c_q <= alu9[8];
            z_q <= (alu9[7:0] == 8'h00);
            s_q <= alu9[7];
            p_q <= ~^alu9[7:0];
         end else if (op_inc || op_dec) begin
            z_q <= (idr == 8'h00);
            s_q <= idr[7];
            p_q <= ~^idr;
         end else if (op_rot) begin
            c_q <= rot_c;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sp_q <= SP_RESET;
         for (int i = 0; i < 8; i++) begin
            stack_q[i] <= PC_RESET;
         end
      end else if (pc_step) begin
         stack_q[sp_q] <= 14'(pc + 14'h0001);
      end else if (done) begin
         if (op_push) begin
            sp_q <= sp_up;
            stack_q[sp_up] <= op_rst ? rst_target : jump_target;
         end else if (op_jump_taken) begin
            stack_q[sp_q] <= jump_target;
         end else if (op_pop) begin
            sp_q <= sp_dn;
         end
      end
   end

   // Checks
   a_load_flags_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      done && op_load |=> $stable(flags))
      else $error("load changed flags");
   a_incdec_carry: assert property (@(posedge mclk) disable iff (!arst_n)
      done && (op_inc || op_dec) |=> c_q == $past(c_q) && z_q == (regs_q[$past(dst)] == 8'h00))
      else $error("inc/dec flag update wrong");
   a_rot_only_carry: assert property (@(posedge mclk) disable iff (!arst_n)
      done && op_rot |=> $stable({p_q, s_q, z_q}) && c_q == $past(rot_c))
      else $error("rotate touched other flags");
   a_cmp_keeps_acc: assert property (@(posedge mclk) disable iff (!arst_n)
      done && op_alu && opc[5:3] == ALU_CMP |=> $stable(regs_q[REG_A]))
      else $error("compare wrote accumulator");
   a_logic_clears_carry: assert property (@(posedge mclk) disable iff (!arst_n)
      done && op_alu && opc[5] && !(opc[4] && opc[3]) |=> !c_q)
      else $error("logical op left carry set");
   a_mem_addr_hl: assert property (@(posedge mclk) disable iff (!arst_n)
      state_q == ST_T1 && use_hl |-> bus_out == regs_q[REG_L] ##1 bus_out[5:0] == regs_q[REG_H][5:0])
      else $error("memory address not from H and L");
   a_fetch_type: assert property (@(posedge mclk) disable iff (!arst_n)
      state_q == ST_T2 && cyc_q == CYC_IDX_FIRST |-> bus_oe && bus_out[7:6] == CYC_FETCH)
      else $error("fetch cycle type wrong");
   a_halt_stops: assert property (@(posedge mclk) disable iff (!arst_n)
      fetch_t3 && op_hlt && !intr_req |=> state_q == ST_STOPPED ##1
      (state_q == ST_STOPPED || $past(intr_req)))
      else $error("halt did not stop");
   a_call_push: assert property (@(posedge mclk) disable iff (!arst_n)
      done && op_push && !op_rst |=> sp_q == 3'($past(sp_q) + 3'h1) && pc == $past(jump_target))
      else $error("call push wrong");
   a_ret_pop: assert property (@(posedge mclk) disable iff (!arst_n)
      done && op_pop |=> sp_q == 3'($past(sp_q) - 3'h1))
      else $error("return pop wrong");
   a_jump_hi_bits: assert property (@(posedge mclk) disable iff (!arst_n)
      done && op_jump_taken |=> pc[13:8] == $past(tmp_hi_q[5:0]))
      else $error("jump high address bits wrong");
   a_io_cycle_type: assert property (@(posedge mclk) disable iff (!arst_n)
      state_q == ST_T2 && cyc_q == CYC_IDX_SECOND && (op_in || op_out) |-> bus_out[7:6] == CYC_IO)
      else $error("I/O cycle type wrong");
   a_store_cycle_type: assert property (@(posedge mclk) disable iff (!arst_n)
      state_q == ST_T2 && cyc_q == CYC_IDX_SECOND && op_lmr |-> bus_out[7:6] == CYC_WRITE)
      else $error("store cycle type wrong");

endmodule

// File: tb/io_mem_model.sv
`timescale 1ns/1ps
module io_mem_model
   import cpu_decode_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Processor bus
   input wire logic [7:0] bus_out,
   input wire logic bus_oe,
   input wire logic [2:0] state_code,
   output logic [7:0] bus_in,
   // Seen writes and outputs
   output logic ev_valid,
   output logic [22:0] ev_data
);
   logic [7:0] mem [0:16383];
   logic [7:0] lo_q, hi_q, pat_q;
   wire [13:0] addr = {hi_q[5:0], lo_q};
   wire [1:0] kind = hi_q[7:6];
   wire in_t3 = state_code == ST_T3;
   wire is_inp = kind == CYC_IO && hi_q[5:4] == 2'h0;
   wire is_rd = kind == CYC_FETCH || kind == CYC_READ;
   wire is_wr = in_t3 && kind == CYC_WRITE && bus_oe;
   wire is_out = in_t3 && kind == CYC_IO && !is_inp;
   // Undriven bus keeps changing so a stale byte never looks valid
   assign bus_in = in_t3 && is_rd ? mem[addr] : in_t3 && is_inp ? {5'h13, hi_q[3:1]} : pat_q;
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         {lo_q, hi_q, pat_q} <= 24'h00003c;
         ev_valid <= 1'b0;
      end else begin
         pat_q <= pat_q + 8'h5b;
         ev_valid <= is_wr || is_out;
         ev_data <= is_wr ? {1'b1, addr, bus_out} : {10'h000, hi_q[5:1], lo_q};
         if (is_wr) begin
            mem[addr] <= bus_out;
         end
         if (state_code == ST_T1) begin
            lo_q <= bus_out;
         end
         if (state_code == ST_T2) begin
            hi_q <= bus_out;
         end
      end
   end
endmodule

// File: tb/cpu_instruction_decoder_bench.sv
`timescale 1ns/1ps
module cpu_instruction_decoder_bench;
   import cpu_decode_pkg::*;
   logic mclk, arst_n, ready, intr_req, bus_oe, ev_valid, rnd_ready, tk;
   logic [7:0] bus_in, bus_out, a, b, y, md;
   logic [2:0] state_code;
   logic [3:0] flags, fl;
   logic [22:0] ev_data;
   logic [13:0] pc;
   logic [7:0] img [0:16383];
   logic [26:0] exp_all [$];
   logic [26:0] exp_q [$];
   int st, st_halt, num_errors, n_checks, cycles, n;
   cpu_instruction_decoder uut (.mclk(mclk), .arst_n(arst_n), .bus_in(bus_in), .bus_out(bus_out),
      .bus_oe(bus_oe), .state_code(state_code), .ready(ready), .intr_req(intr_req), .flags(flags));
   io_mem_model partner (.mclk(mclk), .arst_n(arst_n), .bus_out(bus_out), .bus_oe(bus_oe),
      .state_code(state_code), .bus_in(bus_in), .ev_valid(ev_valid), .ev_data(ev_data));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic report_and_stop();
      if (num_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [26:0] e, input logic [26:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   // Places the first n bytes of v at pc
   task automatic put(input logic [23:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         img[pc] = v[23 - 8 * i -: 8];
         pc++;
      end
   endtask
   task automatic note(input int cost, input logic [22:0] ev);
      st += cost;
      exp_all.push_back({ev, fl});
   endtask
   task automatic out_a(input int cost);
      logic [4:0] p;
      p = 5'(8 + $urandom % 24);
      put({2'b01, p, 1'b1, 16'h0}, 1);
      note(cost + 6, {10'h000, p, a});
   endtask
   task automatic jump_always(input logic [7:0] op, input logic [13:0] tg);
      put({op, tg[7:0], 2'b11, tg[13:8]}, 3);
   endtask
   function automatic logic [11:0] alu(input logic [2:0] op, input logic [7:0] x, input logic [7:0] v);
      logic [8:0] r;
      case (op)
         3'h0: r = {1'b0, x} + {1'b0, v};
         3'h1: r = {1'b0, x} + {1'b0, v} + {8'h00, fl[0]};
         3'h3: r = {1'b0, x} - {1'b0, v} - {8'h00, fl[0]};
         3'h4: r = {1'b0, x & v};
         3'h5: r = {1'b0, x ^ v};
         3'h6: r = {1'b0, x | v};
         default: r = {1'b0, x} - {1'b0, v};
      endcase
      return {~^r[7:0], r[7], r[7:0] == 8'h00, r[8], op == 3'h7 ? x : r[7:0]};
   endfunction
   task automatic build();
      for (int i = 0; i < 16384; i++)
         img[i] = 8'hff;
      for (int k = 1; k < 8; k++) begin
         pc = 14'(8 * k);
         put(24'h510700, 2);
      end
      pc = 14'h0000;
      fl = 4'h0;
      md = 8'($urandom);
      b = 8'($urandom);
      img[14'h1234] = md;
      jump_always(8'h44, 14'h0040);
      pc = 14'h0040;
      put(24'h2ed236, 3);
      put({8'h34, 8'h0e, b}, 3);
      st = 35;
      for (int f = 0; f < 3; f++) begin
         for (int op = 0; op < 8; op++) begin
            a = 8'($urandom);
            y = f == 0 ? b : f == 2 ? md : 8'($urandom);
            put({8'h06, a, 8'h00}, 2);
            if (f == 1) put({2'b00, 3'(op), 3'b100, y, 8'h00}, 2);
            else put({2'b10, 3'(op), f == 0 ? 3'b001 : 3'b111, 16'h0}, 1);
            {fl, a} = alu(3'(op), a, y);
            out_a(f == 0 ? 13 : 16);
         end
      end
      for (int r = 0; r < 4; r++) begin
         put({3'b000, 2'(r), 3'b010, 16'h0}, 1);
         {fl[0], a} = r == 0 ? {a, a[7]} : r == 2 ? {a, fl[0]} :
            r == 1 ? {a[0], a[0], a[7:1]} : {a[0], fl[0], a[7:1]};
         out_a(5);
      end
      put(24'h16ff10, 3);
      put(24'hc211c2, 1);
      {a, fl[3:1]} = {8'h00, 3'b101};
      out_a(18);
      put(24'h11c200, 2);
      {a, fl[3:1]} = {8'hff, 3'b110};
      out_a(10);
      y = 8'($urandom);
      put({8'hf9, 8'h3e, y}, 3);
      note(7, {1'b1, 14'h1234, b});
      note(9, {1'b1, 14'h1234, y});
      put(24'hc70000, 1);
      a = y;
      out_a(8);
      for (int m = 0; m < 8; m++) begin
         put({4'b0100, 3'(m), 1'b1, 16'h0}, 1);
         a = {5'h13, 3'(m)};
         out_a(8);
      end
      for (int s = 0; s < 2; s++) begin
         y = 8'(2 - s);
         put({8'h06, 8'(s + 1), 8'h3c}, 3);
         put({y, 16'h0}, 1);
         {fl, a} = alu(3'h7, 8'(s + 1), y);
         st += 16;
         for (int j = 0; j < 24; j++) begin
            tk = fl[j[1:0]] == j[2];
            if (j < 16) begin
               jump_always({2'b01, 3'(j), j[3] ? 3'b010 : 3'b000}, pc + 14'd5);
               put({8'h06, 8'hf0 ^ 8'(j), 8'h00}, 2);
               a = tk ? a : 8'hf0 ^ 8'(j);
               out_a(tk ? 11 : 17);
            end else begin
               jump_always(8'h46, pc + 14'd7);
               a = tk ? a : 8'he0 ^ 8'(j);
               out_a(tk ? 27 : 38);
               jump_always(8'h44, pc + 14'd7);
               put({2'b00, 3'(j), 3'b011, 8'h06, 8'he0 ^ 8'(j)}, 3);
               put(24'h070000, 1);
            end
         end
      end
      for (int k = 1; k < 8; k++) begin
         put({2'b00, 3'(k), 3'b101, 16'h0}, 1);
         note(16, {10'h000, 5'h08, a});
      end
      st_halt = st + 3;
      put(24'hff065a, 3);
      a = 8'h5a;
      out_a(0);
      put(24'h0006a5, 3);
      a = 8'ha5;
      out_a(0);
      put(24'h010000, 1);
   endtask
   task automatic run(input logic rnd);
      {rnd_ready, arst_n, n} = {rnd, 1'b0, 32'd0};
      for (int i = 0; i < 16384; i++)
         partner.mem[i] = img[i];
      exp_q = exp_all;
      repeat (8) @(negedge mclk);
      arst_n = 1'b1;
      while (state_code !== ST_STOPPED) begin
         @(negedge mclk);
         n++;
      end
      if (!rnd) check("states to halt", 27'(st_halt), 27'(n));
      for (int h = 0; h < 2; h++) begin
         repeat (40) @(negedge mclk);
         check("stopped", 27'(ST_STOPPED), 27'(state_code));
         intr_req = 1'b1;
         @(negedge mclk);
         intr_req = 1'b0;
         @(negedge mclk);
         while (state_code !== ST_STOPPED) @(negedge mclk);
      end
      repeat (4) @(negedge mclk);
      check("events left", 27'h0, 27'(exp_q.size()));
   endtask
   always @(posedge mclk) begin
      if (arst_n && ev_valid) begin
         check("bus event", exp_q.size() > 0 ? exp_q.pop_front() : 27'h0, {ev_data, flags});
      end
   end
   always @(negedge mclk) begin
      ready <= rnd_ready ? 1'($urandom) : 1'b1;
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      {arst_n, ready, intr_req, rnd_ready} = 4'b0100;
      {num_errors, n_checks, cycles} = 96'd0;
      void'($urandom(32'h8070));
      build();
      run(1'b0);
      run(1'b1);
      report_and_stop();
   end
endmodule
